// ===== rtl/sarc_pkg.sv
// constants shared by the converter control, and the successive approximation engine
package sarc_pkg;
  localparam int unsigned RES_BITS  = 12;
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned CNT_BITS  = 5;
  // internal conversion clock: one step every CONV_DIV system clocks
  localparam int unsigned CONV_DIV  = 4;
  localparam logic [2:0]  DIV_LAST  = 3'(CONV_DIV - 1);
  localparam logic [3:0]  IDX_MSB   = 4'(RES_BITS - 1);
  localparam logic [3:0]  IDX_LSB   = 4'h0;
  localparam logic [RES_BITS-1:0] CODE_ZERO = 12'h000;
  localparam logic [RES_BITS-1:0] CODE_ONE  = 12'h001;

  // serial frame layout
  localparam logic [CNT_BITS-1:0] FRAME_LEN = 5'h10;
  localparam int unsigned ADDR_MSB  = 15;
  localparam int unsigned ADDR_LSB  = 11;
  localparam int unsigned RW_POS    = 10;
  localparam logic [4:0]  ADDR_RESULT = 5'h00;
  localparam logic [4:0]  ADDR_CONFIG = 5'h02;

  // configuration word fields
  localparam int unsigned CFG_REF_POS   = 0;
  localparam int unsigned CFG_PD_POS    = 1;
  localparam int unsigned CFG_SRST_POS  = 9;
  localparam logic [1:0]  PWR_DEFAULT   = 2'h0;
  localparam logic [WORD_BITS-1:0] WORD_ZERO = 16'h0000;
  localparam int unsigned RESULT_PAD    = WORD_BITS - RES_BITS;

  typedef enum logic {SARC_IDLE, SARC_CONVERT} sarc_state_e;

  // put the result in the top bits of the outgoing word, zeros below
  function automatic logic [WORD_BITS-1:0] sarc_result_word(input logic [RES_BITS-1:0] code);
    sarc_result_word = {code, {RESULT_PAD{1'b0}}};
  endfunction
endpackage

// successive approximation engine stepped by its own conversion clock
module sarc_sar_engine
  import sarc_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rst_b,
  input  wire logic                soft_clear,
  input  wire logic                start,
  input  wire logic                comp_hi,
  output logic                     busy,
  output logic                     done,
  output logic [RES_BITS-1:0]      dac_code,
  output logic [RES_BITS-1:0]      result
);
  sarc_state_e         state_reg;
  logic [2:0]          div_reg;
  logic [3:0]          idx_reg;
  logic [RES_BITS-1:0] code_reg;
  logic                step;

  // ------------------------------------------------------------
  // conversion clock
  // ------------------------------------------------------------
  // the serial clock never reaches here; steps come from this divider
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= 3'h0;
    end else if (soft_clear || state_reg == SARC_IDLE || div_reg == DIV_LAST) begin
      div_reg <= 3'h0;
    end else begin
      div_reg <= div_reg + 3'h1;
    end
  end
  assign step = (state_reg == SARC_CONVERT) && (div_reg == DIV_LAST);

  // ------------------------------------------------------------
  // bit decisions
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= SARC_IDLE;
      idx_reg   <= IDX_MSB;
      code_reg  <= CODE_ZERO;
      result    <= CODE_ZERO;
      done      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (soft_clear) begin
        state_reg <= SARC_IDLE;
        idx_reg   <= IDX_MSB;
        code_reg  <= CODE_ZERO;
        result    <= CODE_ZERO;
      end else begin
        unique case (state_reg)
          SARC_IDLE: begin
            if (start) begin
              state_reg <= SARC_CONVERT;
              idx_reg   <= IDX_MSB;
              code_reg  <= CODE_ONE << IDX_MSB;
            end
          end
          SARC_CONVERT: begin
            if (step) begin
              // keep the trial bit only if comp_hi says the input is at or above the trial level
              if (idx_reg == IDX_LSB) begin
                result    <= comp_hi ? code_reg : (code_reg & ~CODE_ONE);
                done      <= 1'b1;
                state_reg <= SARC_IDLE;
                code_reg  <= CODE_ZERO;
              end else begin
                code_reg <= (comp_hi ? code_reg : (code_reg & ~(CODE_ONE << idx_reg)))
                            | (CODE_ONE << (idx_reg - 4'h1));
                idx_reg  <= idx_reg - 4'h1;
              end
            end
          end
        endcase
      end
    end
  end

  assign busy     = (state_reg == SARC_CONVERT);
  assign dac_code = code_reg;
endmodule

// ===== rtl/sarc_ctrl.sv
// converter control: serial port, configuration, reference, power and reset handling
module sarc_ctrl
  import sarc_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rst_b,
  input  wire logic                sclk,
  input  wire logic                cs_b,
  input  wire logic                serial_command_in,
  input  wire logic                conversion_trigger,
  input  wire logic                comp_hi,
  output logic                     serial_result_out,
  output logic                     serial_result_oe,
  output logic                     track_hold,
  output logic                     conv_power_en,
  output logic                     ref_internal_en,
  output logic [RES_BITS-1:0]      dac_trial,
  output logic                     conv_done
);
  logic                  sclk_q;
  logic                  cs_q;
  logic                  trig_q;
  logic                  sclk_fall;
  logic                  cs_fall;
  logic                  cs_rise;
  logic                  trig_fall;
  logic [CNT_BITS-1:0]   bit_cnt_reg;
  logic [WORD_BITS-1:0]  rx_reg;
  logic [WORD_BITS-1:0]  tx_reg;
  logic [1:0]            pwr_reg;
  logic                  read_cfg_reg;
  logic                  soft_rst_reg;
  logic                  eng_busy;
  logic                  eng_done;
  logic [RES_BITS-1:0]   eng_code;
  logic [RES_BITS-1:0]   eng_result;
  logic                  frame_ok;
  logic                  is_write;
  logic [4:0]            frame_addr;
  logic [WORD_BITS-1:0]  cfg_word;
  logic [WORD_BITS-1:0]  load_word;

  // ------------------------------------------------------------
  // edge detection on link pins
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
      trig_q <= 1'b1;
    end else begin
      sclk_q <= sclk;
      cs_q   <= cs_b;
      trig_q <= conversion_trigger;
    end
  end

  assign sclk_fall  = sclk_q && !sclk && !cs_b;
  assign cs_fall    = cs_q && !cs_b;
  assign cs_rise    = !cs_q && cs_b;
  assign trig_fall  = trig_q && !conversion_trigger;
  assign frame_ok   = (bit_cnt_reg == FRAME_LEN);
  assign frame_addr = rx_reg[ADDR_MSB:ADDR_LSB];
  assign is_write   = rx_reg[RW_POS];
  assign cfg_word   = {{(WORD_BITS-2){1'b0}}, pwr_reg};
  assign load_word  = read_cfg_reg ? cfg_word : sarc_result_word(eng_result);

  // ------------------------------------------------------------
  // serial receive
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_reg <= '0;
      rx_reg      <= WORD_ZERO;
    end else if (cs_fall) begin
      bit_cnt_reg <= '0;
      rx_reg      <= WORD_ZERO;
    end else if (sclk_fall) begin
      rx_reg <= {rx_reg[WORD_BITS-2:0], serial_command_in};
      if (bit_cnt_reg != FRAME_LEN) begin
        bit_cnt_reg <= bit_cnt_reg + 5'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // serial transmit
  // ------------------------------------------------------------
  // the word is frozen at select fall so a conversion ending mid-frame cannot tear it
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_reg            <= WORD_ZERO;
      serial_result_out <= 1'b0;
      serial_result_oe  <= 1'b0;
    end else begin
      serial_result_oe <= !cs_b;
      if (cs_fall) begin
        tx_reg            <= load_word;
        serial_result_out <= load_word[WORD_BITS-1];
      end else if (sclk_fall) begin
        tx_reg            <= {tx_reg[WORD_BITS-2:0], 1'b0};
        serial_result_out <= tx_reg[WORD_BITS-2];
      end else if (cs_b) begin
        serial_result_out <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // configuration and software reset
  // ------------------------------------------------------------
  // partial frames are dropped: only a frame of at least 16 clocks commits at select rise
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pwr_reg      <= PWR_DEFAULT;
      read_cfg_reg <= 1'b0;
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= 1'b0;
      if (soft_rst_reg) begin
        pwr_reg      <= PWR_DEFAULT;
        read_cfg_reg <= 1'b0;
      end else if (cs_rise && frame_ok) begin
        read_cfg_reg <= 1'b0;
        if (is_write && frame_addr == ADDR_CONFIG) begin
          if (rx_reg[CFG_SRST_POS]) begin
            soft_rst_reg <= 1'b1;
          end else begin
            pwr_reg <= {rx_reg[CFG_PD_POS], rx_reg[CFG_REF_POS]};
          end
        end else if (!is_write && frame_addr == ADDR_CONFIG) begin
          read_cfg_reg <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // converter, reference and power outputs
  // ------------------------------------------------------------
  sarc_sar_engine u_engine (
    .clock      (clock),
    .rst_b      (rst_b),
    .soft_clear (soft_rst_reg),
    .start      (trig_fall && !pwr_reg[CFG_PD_POS]),
    .comp_hi    (comp_hi),
    .busy       (eng_busy),
    .done       (eng_done),
    .dac_code   (eng_code),
    .result     (eng_result)
  );

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      track_hold      <= 1'b0;
      conv_power_en   <= 1'b0;
      ref_internal_en <= 1'b0;
      dac_trial       <= CODE_ZERO;
      conv_done       <= 1'b0;
    end else begin
      // hold from the trigger edge until the last decision is made
      track_hold      <= eng_busy;
      conv_power_en   <= eng_busy;
      ref_internal_en <= pwr_reg[CFG_REF_POS] && !pwr_reg[CFG_PD_POS] && !soft_rst_reg;
      dac_trial       <= eng_code;
      conv_done       <= eng_done;
    end
  end
endmodule

// ===== tb/sarc_ctrl_assertions.sv
// port checker for the converter control
module sarc_ctrl_chk
  import sarc_pkg::*;
(
  input wire logic                clock,
  input wire logic                rst_b,
  input wire logic                sclk,
  input wire logic                cs_b,
  input wire logic                conversion_trigger,
  input wire logic                serial_result_out,
  input wire logic                serial_result_oe,
  input wire logic                track_hold,
  input wire logic                conv_power_en,
  input wire logic                ref_internal_en,
  input wire logic [RES_BITS-1:0] dac_trial,
  input wire logic                conv_done
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic trig_q;
  logic sclk_q;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      trig_q <= 1'b1;
      sclk_q <= 1'b1;
    end else begin
      trig_q <= conversion_trigger;
      sclk_q <= sclk;
    end
  end
  wire trig_fall = trig_q & ~conversion_trigger;
  wire sclk_fall = sclk_q & ~sclk;
  sequence s_conv_run;
    (conv_power_en && !conv_done) throughout ##40 1'b1;
  endsequence
  sequence s_conv_end;
    ##[0:19] conv_done;
  endsequence
  a_hold_on_trigger: assert property ($rose(track_hold) |-> $past(trig_fall, 2))
    else $error("hold began without a trigger fall");
  a_conv_duration: assert property ($rose(conv_power_en) |-> s_conv_run ##1 s_conv_end)
    else $error("conversion length out of range");
  a_power_drops: assert property (conv_done |-> ##[0:1] !conv_power_en)
    else $error("power stayed on after conversion");
  a_done_single: assert property (conv_done |=> !conv_done)
    else $error("done longer than one cycle");
  a_dac_first_trial: assert property ($rose(conv_power_en) |-> ##[0:4] dac_trial == 12'h800)
    else $error("first trial is not mid scale");
  a_out_idle_low: assert property (cs_b && $past(cs_b) |-> !serial_result_out)
    else $error("serial output not low while idle");
  a_out_on_fall: assert property ($changed(serial_result_out) && !$past(cs_b)
    && !$past(cs_b, 2) && !$past(cs_b, 3) |-> $past(sclk_fall))
    else $error("serial output moved without a clock fall");
  a_ref_after_frame: assert property ($rose(ref_internal_en) |->
    $past(cs_b, 2) && !$past(cs_b, 3))
    else $error("reference enabled outside a frame commit");
  a_oe_follows_select: assert property (serial_result_oe == !$past(cs_b))
    else $error("output enable does not follow select");
endmodule

bind sarc_ctrl sarc_ctrl_chk i_sarc_ctrl_chk (.clock, .rst_b, .sclk, .cs_b,
  .conversion_trigger, .serial_result_out, .serial_result_oe, .track_hold, .conv_power_en,
  .ref_internal_en, .dac_trial, .conv_done);

// ===== tb/sarc_host_model.sv
// host side: serial frames, clock still and data line toggled between frames
module sarc_host_model (
  input  wire logic clock,
  input  wire logic serial_result_out,
  output logic      sclk,
  output logic      cs_b,
  output logic      serial_command_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'b1;
    cs_b = 1'b1;
    serial_command_in = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  // fewer than 16 falls makes a frame the device must ignore
  task automatic xfer(input logic [15:0] cmd, input int nb, output logic [15:0] rsp);
    rsp = 16'h0000;
    cs_b <= 1'b0;
    wt(3);
    for (int i = 15; i > 15 - nb; i--) begin
      serial_command_in <= cmd[i];
      wt(3);
      rsp[i] = serial_result_out;
      sclk <= 1'b0;
      wt(3);
      sclk <= 1'b1;
    end
    wt(3);
    cs_b <= 1'b1;
    serial_command_in <= ~serial_command_in;
    wt(4);
  endtask
endmodule

// ===== tb/sarc_ctrl_tb.sv
// self-checking bench for the converter control
module sarc_ctrl_tb
  import sarc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(nm, ex, gt) begin tests_run++; if ((gt) !== (ex)) begin err_total++; \
  $display("ERROR %s expected %h seen %h", nm, ex, gt); end end
  logic                clock, rst_b, trig, result_bit, oe, hold, pwr, ref_en, done;
  logic                sclk, cs_b, cmd_bit;
  logic [RES_BITS-1:0] ain, dac;
  logic [15:0]         rsp;
  int                  err_total, tests_run;
  wire                 comp_hi = (ain >= dac);
  sarc_ctrl i_sarc_ctrl (.clock, .rst_b, .sclk, .cs_b, .serial_command_in(cmd_bit),
    .conversion_trigger(trig), .comp_hi, .serial_result_out(result_bit), .serial_result_oe(oe),
    .track_hold(hold), .conv_power_en(pwr), .ref_internal_en(ref_en), .dac_trial(dac),
    .conv_done(done));
  sarc_host_model i_sarc_host_model (.clock, .serial_result_out(result_bit), .sclk, .cs_b,
    .serial_command_in(cmd_bit));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic cfg(input logic [15:0] d);
    i_sarc_host_model.xfer(16'h1400 | d, 16, rsp);
    @(posedge clock);
  endtask
  task automatic read_cfg(input logic [15:0] ex);
    i_sarc_host_model.xfer(16'h1000, 16, rsp);
    i_sarc_host_model.xfer(16'h0000, 16, rsp);
    `CHK("config word", ex, rsp)
  endtask
  task automatic convert(input logic [11:0] code, input logic go);
    int   n;
    logic saw;
    saw = 1'b0;
    n = 0;
    ain  <= code;
    trig <= 1'b0;
    while (done !== 1'b1 && n < 80) begin
      @(posedge clock);
      saw |= (hold === 1'b1);
      n++;
    end
    trig <= 1'b1;
    `CHK("conversion ran", go, n < 80)
    if (go && n >= 80) end_sim();
    if (go) begin
      `CHK("hold seen", 1'b1, saw)
      @(posedge clock);
      `CHK("power off", 1'b0, pwr)
      i_sarc_host_model.xfer(16'h0000, 16, rsp);
      `CHK("result word", {code, 4'h0}, rsp)
    end
  endtask
  task automatic t_defaults();
    `CHK("ref at start", 1'b0, ref_en)
    `CHK("power at start", 1'b0, pwr)
    read_cfg(16'h0000);
  endtask
  task automatic t_ref();
    cfg(16'h0001);
    `CHK("ref on", 1'b1, ref_en)
    read_cfg(16'h0001);
    cfg(16'h0000);
    `CHK("ref off", 1'b0, ref_en)
  endtask
  task automatic t_conv();
    logic [11:0] codes [5] = '{12'h000, 12'hfff, 12'h800, 12'h7ff, 12'ha5c};
    // external reference stays selected here, so no buffer start-up wait is owed
    foreach (codes[i]) convert(codes[i], 1'b1);
  endtask
  task automatic t_pd();
    cfg(16'h0003);
    `CHK("ref in power-down", 1'b0, ref_en)
    convert(12'h123, 1'b0);
    cfg(16'h0000);
    convert(12'h3c5, 1'b1);
  endtask
  task automatic t_resets();
    cfg(16'h0001);
    cfg(16'h0200);
    `CHK("ref after soft reset", 1'b0, ref_en)
    read_cfg(16'h0000);
    cfg(16'h0001);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    `CHK("ref after hard reset", 1'b0, ref_en)
    `CHK("oe after hard reset", 1'b0, oe)
    read_cfg(16'h0000);
  endtask
  task automatic t_short();
    i_sarc_host_model.xfer(16'h1401, 15, rsp);
    @(posedge clock);
    `CHK("short frame ignored", 1'b0, ref_en)
    cfg(16'h0001);
    `CHK("full frame taken", 1'b1, ref_en)
    cfg(16'h0000);
  endtask
  initial begin
    err_total = 0;
    tests_run = 0;
    rst_b = 1'b0;
    trig = 1'b1;
    ain = 12'h000;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
    t_defaults();
    t_ref();
    t_conv();
    t_pd();
    t_resets();
    t_short();
    end_sim();
  end
endmodule
